//--- testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic       i_clk,
  // serial pins
  output logic            o_sck,
  output logic            o_cs_n,
  output logic      [3:0] o_dq,
  input  wire logic [3:0] i_dq,
  input  wire logic [3:0] i_dq_oe_n
);
  // released lines float high through pull-ups
  logic [3:0] line;
  assign line = i_dq_oe_n | i_dq;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'h0;
  end

  // one frame: ntx bits out, nrx bits in, w lines; never deep power-down
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx, input int w,
                       output logic [23:0] rx);
    logic [39:0] sh;
    sh = tx;
    rx = 24'h0;
    @(posedge i_clk) o_cs_n <= 1'b0;
    for (int i = 0; i < ntx + nrx; i += w) begin
      @(posedge i_clk);
      if (i < ntx) o_dq <= (w == 1) ? {~o_dq[3:1], sh[39]} : sh[39:36];
      else o_dq <= ~o_dq;
      sh = sh << w;
      repeat (8) @(posedge i_clk);
      o_sck <= 1'b1;
      if (i >= ntx) rx = (w == 1) ? {rx[22:0], line[1]} : {rx[19:0], line};
      repeat (8) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (12) @(posedge i_clk);
  endtask : frame
endmodule : spi_host_model

//--- testbench/test_flash_id_and_otp_mode.sv
`timescale 1ns/1ps
module test_flash_id_and_otp_mode;
  localparam int          LOCK = 300;
  localparam logic [23:0] ID   = {flash_otp_pkg::ID_MANUFACTURER, flash_otp_pkg::ID_MEM_TYPE,
                                  flash_otp_pkg::ID_CAPACITY};
  logic        clk;
  logic        rst;
  logic        sck;
  logic        cs_n;
  logic [3:0]  dq;
  logic [3:0]  dq_o;
  logic [3:0]  oe_n;
  logic        busy;
  logic        lock_st;
  logic [23:0] addr;
  logic        sel, se, be, ce, pp, lp, otp, quad;
  logic [2:0]  pf;
  logic [27:0] ev;
  logic        ev_clr;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          seed     = 32'h6b85;
  int          m_wel, m_otp, m_lock, m_pf, m_spb, m_quad, m_live;

  flash_id_otp_ctrl #(.LOCKOUT_CYCLES(LOCK)) dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_DQ(dq), .O_DQ(dq_o),
    .O_DQ_OE_N(oe_n), .I_ARRAY_BUSY(busy), .I_LOCK_STORED(lock_st), .O_ADDR(addr),
    .O_OTP_SEL(sel), .O_SECTOR_ERASE(se), .O_BLOCK_ERASE(be), .O_CHIP_ERASE(ce),
    .O_PAGE_PROGRAM(pp), .O_LOCK_PROGRAM(lp), .O_OTP_MODE(otp), .O_QUAD_MODE(quad),
    .O_BLOCK_PROTECT(pf));

  spi_host_model host (.i_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_dq(dq), .i_dq(dq_o),
                       .i_dq_oe_n(oe_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // records the last array operation as {kind, otp target, address}
  always @(posedge clk) begin
    if (ev_clr) ev <= 28'h0;
    if (se | be | pp) ev <= {se ? 3'd1 : be ? 3'd2 : 3'd4, sel, addr};
    if (ce) ev <= {3'd3, 25'h0};
    if (lp) ev <= {3'd5, 25'h0};
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk_reply(input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t reply exp %h got %h", $time, e, g);
    end
  endtask : chk_reply

  task automatic chk_op(input logic [27:0] e, input logic [27:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t operation exp %h got %h", $time, e, g);
    end
  endtask : chk_op

  task automatic model_reset();
    m_wel  = 0;
    m_otp  = 0;
    m_lock = 0;
    m_pf   = 0;
    m_spb  = 0;
    m_quad = 0;
    m_live = 0;
  endtask : model_reset

  function automatic logic [23:0] st();
    return {16'h0, (m_otp != 0) ? m_lock[0] : m_spb[0], 2'b00, m_pf[2:0], m_wel[0], 1'b0};
  endfunction : st

  // sends one instruction frame and checks the operation it launches
  task automatic cmd(input logic [7:0] c, input logic [23:0] a);
    logic [27:0] e;
    logic [23:0] rx;
    logic        s;
    e = 28'h0;
    @(posedge clk) ev_clr <= 1'b1;
    @(posedge clk) ev_clr <= 1'b0;
    host.frame({c, a, 8'h5a}, (c == 8'h01) ? 16 : (c == 8'h02) ? 40 :
               (c == 8'h20 || c == 8'hd8) ? 32 : 8, 0, (m_quad != 0) ? 4 : 1, rx);
    case (c)
      8'h06: m_wel = m_live;
      8'h04: begin
        m_wel = 0;
        m_otp = 0;
      end
      8'h3a: m_otp = 1;
      8'h38: m_quad = 1;
      8'hff: m_quad = 0;
      8'h01: if (m_wel != 0) begin
        m_wel = 0;
        if (m_otp != 0) begin
          m_lock = 1;
          e = {3'd5, 25'h0};
        end else begin
          m_spb = a[23];
          m_pf = a[20:18];
        end
      end
      8'hc7: if (m_wel != 0 && m_pf == 0) begin
        m_wel = 0;
        e = {3'd3, 25'h0};
      end
      default: begin
        s = m_otp != 0 && c != 8'hd8 && a >= flash_otp_pkg::OTP_FIRST &&
            a <= flash_otp_pkg::OTP_LAST;
        if (m_wel != 0 && (s ? (m_lock == 0 && m_pf == 0) : (m_otp == 0 || m_lock == 0))) begin
          m_wel = 0;
          e = {(c == 8'h20) ? 3'd1 : (c == 8'hd8) ? 3'd2 : 3'd4, s, a};
        end
      end
    endcase
    chk_op(e, ev);
    chk_reply({19'h0, m_otp[0], m_quad[0], m_pf[2:0]}, {19'h0, otp, quad, pf});
  endtask : cmd

  task automatic wr(input logic [7:0] c, input logic [23:0] a);
    cmd(8'h06, 24'h0);
    cmd(c, a);
  endtask : wr

  // reads n reply bits and checks that the outputs are released afterwards
  task automatic rd(input logic [7:0] c, input int n, input logic [23:0] e);
    logic [23:0] rx;
    host.frame({c, 32'h0}, 8, n, (m_quad != 0) ? 4 : 1, rx);
    chk_reply(e, rx);
    chk_reply(24'hf, {20'h0, oe_n});
  endtask : rd

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    lock_st = 1'b0;
    ev_clr = 1'b1;
    model_reset();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(8'h20, 24'h001000);
    rd(8'h05, 8, st());
    repeat (LOCK) @(posedge clk);
    m_live = 1;
    $display("lockout test done");
    rd(8'h9f, 24, ID);
    rd(8'h9f, 8, {16'h0, ID[23:16]});
    busy <= 1'b1;
    rd(8'h9f, 24, 24'hffffff);
    busy <= 1'b0;
    $display("identification test done");
    wr(8'h01, 24'h8c0000);
    rd(8'h05, 8, st());
    wr(8'hc7, 24'h0);
    wr(8'h01, 24'h800000);
    wr(8'hc7, 24'h0);
    $display("protect test done");
    cmd(8'h38, 24'h0);
    rd(8'h9f, 24, ID);
    cmd(8'h3a, 24'h0);
    rd(8'h05, 8, st());
    cmd(8'h04, 24'h0);
    cmd(8'hff, 24'h0);
    $display("quad test done");
    cmd(8'h3a, 24'h0);
    for (int i = 0; i < 6; i++) begin
      wr(i[0] ? 8'h02 : 8'h20, {12'h07f, 12'($random(seed)) & 12'h1ff});
    end
    wr(8'hd8, 24'h07f000);
    wr(8'h01, 24'h9c0000);
    rd(8'h05, 8, st());
    wr(8'h20, 24'h07f000);
    wr(8'h02, 24'h001000);
    cmd(8'h04, 24'h0);
    rd(8'h05, 8, st());
    wr(8'h20, 24'h07f000);
    cmd(8'h3a, 24'h0);
    rd(8'h05, 8, st());
    $display("otp test done");
    lock_st <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    model_reset();
    m_lock = 1;
    cmd(8'h3a, 24'h0);
    rd(8'h05, 8, st());
    $display("stored lock test done");
    complete_run();
  end
endmodule : test_flash_id_and_otp_mode

//--- verilog/flash_id_otp_ctrl.sv
`timescale 1ns/1ps
// Operation
// RQ1: 9Fh after select returns 24 identification bits
// RQ2: order: manufacturer, memory type, capacity
// RQ3: output bits change on serial clock fall
// RQ4: identification ignored while erase/program runs
// RQ5: host avoids identification in deep power-down
// RQ6: chip select high stops output, standby
// RQ7: identification and otp entry in quad too
// RQ8: 3Ah enters otp mode before otp access
// RQ9: otp sector replaces 07F000h-07F0FFh
// RQ10: status protect bit reports otp lock
// RQ11: otp lock set refuses program and erase
// RQ12: otp write status only sets lock
// RQ13: otp sector writable: unlocked, protect 000
// RQ14: otp mode: others writable only unlocked
// RQ15: host clears protect bits before otp entry
// RQ16: 04h leaves otp mode, normal mapping
// RQ17: only 20h erases otp data
// RQ18: writes rejected 1 to 10 ms after power-up
// RQ19: delivered status reads 00h
// RQ20: chip erase only with protect field zero
// RQ21: otp lock never clears once set
module flash_id_otp_ctrl #(
  parameter int unsigned LOCKOUT_CYCLES = flash_otp_pkg::LOCKOUT_CYC
) (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  // serial pins
  input  wire logic        I_SCK,
  input  wire logic        I_CS_N,
  input  wire logic [3:0]  I_DQ,
  output logic      [3:0]  O_DQ,
  output logic      [3:0]  O_DQ_OE_N,
  // array back end
  input  wire logic        I_ARRAY_BUSY,
  input  wire logic        I_LOCK_STORED,
  output logic [23:0]      O_ADDR,
  output logic             O_OTP_SEL,
  output logic             O_SECTOR_ERASE,
  output logic             O_BLOCK_ERASE,
  output logic             O_CHIP_ERASE,
  output logic             O_PAGE_PROGRAM,
  output logic             O_LOCK_PROGRAM,
  // mode status
  output logic             O_OTP_MODE,
  output logic             O_QUAD_MODE,
  output logic [2:0]       O_BLOCK_PROTECT
);

  typedef struct packed {
    flash_otp_pkg::ctrl_state_t          state;
    logic [7:0]                          cmd;
    logic [1:0]                          nbyte;
    logic [23:0]                         addr;
    logic [7:0]                          wsr_data;
    logic [1:0]                          busy_s;
    logic [1:0]                          nv_s;
    logic                                otp_mode;
    logic                                quad;
    logic                                wel;
    logic                                pbit;
    logic [2:0]                          pfield;
    logic                                lock;
    logic [flash_otp_pkg::LOCKOUT_W-1:0] pwr_cnt;
    logic                                pwr_done;
    logic                                tx_load;
    logic [23:0]                         tx_word;
    logic [4:0]                          tx_bits;
    logic [23:0]                         addr_o;
    logic                                otp_sel;
    logic                                se_go;
    logic                                be_go;
    logic                                ce_go;
    logic                                pp_go;
    logic                                lock_go;
  } ctrl_st_t;

  ctrl_st_t st_q, st_d;
  shift_if  sif ();

  logic       busy;
  logic       otp_tgt;
  logic       wr_base;
  logic       wr_otp;
  logic       wr_main;
  logic [7:0] status_byte;

  serial_shifter u_shifter (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .i_sck     (I_SCK),
    .i_cs_n    (I_CS_N),
    .i_dq      (I_DQ),
    .o_dq      (O_DQ),
    .o_dq_oe_n (O_DQ_OE_N),
    .sif       (sif)
  );

  assign busy    = st_q.busy_s[1];
  // otp window decode (see RQ9)
  assign otp_tgt = st_q.otp_mode && (st_q.addr >= flash_otp_pkg::OTP_FIRST)
                   && (st_q.addr <= flash_otp_pkg::OTP_LAST);
  // write gates: enable latch, idle array, lockout over (see RQ18)
  assign wr_base = st_q.wel && !busy && st_q.pwr_done;
  // otp sector needs lock clear and protect field zero (see RQ13)
  assign wr_otp  = wr_base && !st_q.lock && (st_q.pfield == 3'b000);
  // other sectors in otp mode need lock clear (see RQ11) (see RQ14)
  assign wr_main = wr_base && !(st_q.otp_mode && st_q.lock);
  // protect position shows the lock in otp mode (see RQ10)
  assign status_byte = {(st_q.otp_mode ? st_q.lock : st_q.pbit), 2'b00,
                        st_q.pfield, st_q.wel, busy};

  always_comb begin
    st_d         = st_q;
    st_d.tx_load = 1'b0;
    st_d.se_go   = 1'b0;
    st_d.be_go   = 1'b0;
    st_d.ce_go   = 1'b0;
    st_d.pp_go   = 1'b0;
    st_d.lock_go = 1'b0;
    st_d.busy_s  = {st_q.busy_s[0], I_ARRAY_BUSY};
    st_d.nv_s    = {st_q.nv_s[0], I_LOCK_STORED};
    // stored lock is only ever added to, never cleared (see RQ21)
    st_d.lock    = st_q.lock | st_q.nv_s[1];
    if (!st_q.pwr_done) begin
      if (st_q.pwr_cnt >= LOCKOUT_CYCLES[flash_otp_pkg::LOCKOUT_W-1:0] - 1'b1) begin
        st_d.pwr_done = 1'b1; // see RQ18
      end else begin
        st_d.pwr_cnt = st_q.pwr_cnt + 1'b1;
      end
    end
    if (sif.frame_start) begin
      st_d.state = flash_otp_pkg::S_CMD;
      st_d.nbyte = 2'h0;
    end else if (sif.frame_end) begin
      // deselect: back to standby, decode anew (see RQ6)
      st_d.state = flash_otp_pkg::S_CMD;
      if (st_q.state == flash_otp_pkg::S_DONE) begin
        case (st_q.cmd)
          flash_otp_pkg::OP_WRITE_EN: begin
            st_d.wel = st_q.pwr_done; // see RQ18
          end
          flash_otp_pkg::OP_WRITE_DIS: begin
            st_d.wel      = 1'b0;
            st_d.otp_mode = 1'b0; // see RQ16
          end
          flash_otp_pkg::OP_OTP_ENTER: begin
            st_d.otp_mode = 1'b1; // see RQ8
          end
          flash_otp_pkg::OP_QUAD_ENABLE: begin
            st_d.quad = 1'b1;
          end
          flash_otp_pkg::OP_QUAD_RESET: begin
            st_d.quad = 1'b0;
          end
          flash_otp_pkg::OP_WRITE_STAT: begin
            if (wr_base) begin
              st_d.wel = 1'b0;
              if (st_q.otp_mode) begin
                st_d.lock    = 1'b1; // see RQ12
                st_d.lock_go = 1'b1;
              end else begin
                st_d.pbit   = st_q.wsr_data[7];
                st_d.pfield = st_q.wsr_data[4:2];
              end
            end
          end
          flash_otp_pkg::OP_SECT_ERASE: begin
            // the only erase that reaches otp data (see RQ17)
            if (otp_tgt ? wr_otp : wr_main) begin
              st_d.se_go   = 1'b1;
              st_d.wel     = 1'b0;
              st_d.addr_o  = st_q.addr;
              st_d.otp_sel = otp_tgt;
            end
          end
          flash_otp_pkg::OP_PAGE_PROG: begin
            if (otp_tgt ? wr_otp : wr_main) begin
              st_d.pp_go   = 1'b1;
              st_d.wel     = 1'b0;
              st_d.addr_o  = st_q.addr;
              st_d.otp_sel = otp_tgt;
            end
          end
          flash_otp_pkg::OP_BLOCK_ERASE: begin
            if (wr_main) begin
              st_d.be_go   = 1'b1;
              st_d.wel     = 1'b0;
              st_d.addr_o  = st_q.addr;
              st_d.otp_sel = 1'b0; // see RQ17
            end
          end
          flash_otp_pkg::OP_CHIP_ERASE: begin
            if (wr_main && st_q.pfield == 3'b000) begin
              st_d.ce_go   = 1'b1; // see RQ20
              st_d.wel     = 1'b0;
              st_d.otp_sel = 1'b0;
            end
          end
          default: begin
            st_d.otp_sel = st_q.otp_sel;
          end
        endcase
      end
    end else if (sif.rx_valid) begin
      case (st_q.state)
        flash_otp_pkg::S_CMD: begin
          st_d.cmd   = sif.rx_byte;
          st_d.nbyte = 2'h0;
          case (sif.rx_byte)
            flash_otp_pkg::OP_READ_ID: begin
              if (busy) begin
                st_d.state = flash_otp_pkg::S_SKIP; // see RQ4
              end else begin
                // manufacturer, type, capacity (see RQ1) (see RQ2)
                st_d.state   = flash_otp_pkg::S_TX;
                st_d.tx_load = 1'b1;
                st_d.tx_word = {flash_otp_pkg::ID_MANUFACTURER,
                                flash_otp_pkg::ID_MEM_TYPE,
                                flash_otp_pkg::ID_CAPACITY};
                st_d.tx_bits = flash_otp_pkg::ID_BITS;
              end
            end
            flash_otp_pkg::OP_READ_STATUS: begin
              st_d.state   = flash_otp_pkg::S_TX;
              st_d.tx_load = 1'b1;
              st_d.tx_word = {status_byte, 16'h0000};
              st_d.tx_bits = flash_otp_pkg::STATUS_BITS;
            end
            flash_otp_pkg::OP_SECT_ERASE, flash_otp_pkg::OP_BLOCK_ERASE,
            flash_otp_pkg::OP_PAGE_PROG: begin
              st_d.state = flash_otp_pkg::S_ADDR;
            end
            flash_otp_pkg::OP_WRITE_STAT: begin
              st_d.state = flash_otp_pkg::S_WSR;
            end
            default: begin
              st_d.state = flash_otp_pkg::S_DONE;
            end
          endcase
        end
        flash_otp_pkg::S_ADDR: begin
          st_d.addr  = {st_q.addr[15:0], sif.rx_byte};
          st_d.nbyte = st_q.nbyte + 2'h1;
          if (st_q.nbyte == flash_otp_pkg::ADDR_BYTES - 2'h1) begin
            st_d.state = flash_otp_pkg::S_DONE;
          end
        end
        flash_otp_pkg::S_WSR: begin
          st_d.wsr_data = sif.rx_byte;
          st_d.state    = flash_otp_pkg::S_DONE;
        end
        flash_otp_pkg::S_DONE: begin
          if (st_q.cmd != flash_otp_pkg::OP_PAGE_PROG) begin
            st_d.state = flash_otp_pkg::S_SKIP;
          end
        end
        default: begin
          st_d.state = st_q.state;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q       <= '0; // status reads 00h after reset (see RQ19)
      st_q.state <= flash_otp_pkg::S_CMD;
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.quad        = st_q.quad;
  assign sif.tx_load     = st_q.tx_load;
  assign sif.tx_word     = st_q.tx_word;
  assign sif.tx_bits     = st_q.tx_bits;
  assign O_ADDR          = st_q.addr_o;
  assign O_OTP_SEL       = st_q.otp_sel;
  assign O_SECTOR_ERASE  = st_q.se_go;
  assign O_BLOCK_ERASE   = st_q.be_go;
  assign O_CHIP_ERASE    = st_q.ce_go;
  assign O_PAGE_PROGRAM  = st_q.pp_go;
  assign O_LOCK_PROGRAM  = st_q.lock_go;
  assign O_OTP_MODE      = st_q.otp_mode;
  assign O_QUAD_MODE     = st_q.quad;
  assign O_BLOCK_PROTECT = st_q.pfield;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_id_req;
    st_q.state == flash_otp_pkg::S_CMD && sif.rx_valid && !sif.frame_end
    && !sif.frame_start && sif.rx_byte == flash_otp_pkg::OP_READ_ID;
  endsequence
  sequence s_id_load;
    st_q.tx_load && st_q.tx_bits == 5'h18 && st_q.tx_word[23:16] == 8'h5a
    && st_q.tx_word[15:8] == 8'h30 && st_q.tx_word[7:0] == 8'h13;
  endsequence
  sequence s_done_end(logic [7:0] op);
    sif.frame_end && st_q.state == flash_otp_pkg::S_DONE && st_q.cmd == op;
  endsequence

  property p_id_reply;
    s_id_req ##0 !busy |=> s_id_load;
  endproperty
  a_id_reply: assert property (p_id_reply) else $error("id reply wrong"); // see RQ1

  property p_id_busy;
    s_id_req ##0 busy |=> !st_q.tx_load && st_q.state == flash_otp_pkg::S_SKIP;
  endproperty
  a_id_busy: assert property (p_id_busy) else $error("id decoded while busy"); // see RQ4

  property p_otp_enter;
    s_done_end(flash_otp_pkg::OP_OTP_ENTER) |=> st_q.otp_mode ##1 st_q.otp_mode;
  endproperty
  a_otp_enter: assert property (p_otp_enter) else $error("otp entry missed"); // see RQ8

  property p_otp_exit;
    s_done_end(flash_otp_pkg::OP_WRITE_DIS) |=> !st_q.otp_mode && !st_q.wel;
  endproperty
  a_otp_exit: assert property (p_otp_exit) else $error("otp exit missed"); // see RQ16

  property p_lock_refuse;
    (st_q.se_go || st_q.pp_go || st_q.be_go || st_q.ce_go)
    |-> !($past(st_q.otp_mode) && $past(st_q.lock));
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("write while locked"); // see RQ11

  property p_wsr_lock;
    s_done_end(flash_otp_pkg::OP_WRITE_STAT) ##0 st_q.otp_mode && wr_base
    |=> st_q.lock && st_q.lock_go && $stable(st_q.pfield) && $stable(st_q.pbit);
  endproperty
  a_wsr_lock: assert property (p_wsr_lock) else $error("otp status write wrong"); // see RQ12

  property p_status_lock;
    st_q.state == flash_otp_pkg::S_CMD && sif.rx_valid && !sif.frame_end
    && !sif.frame_start && sif.rx_byte == flash_otp_pkg::OP_READ_STATUS
    && st_q.otp_mode |=> st_q.tx_word[23] == $past(st_q.lock);
  endproperty
  a_status_lock: assert property (p_status_lock) else $error("status lock bit wrong"); // see RQ10

  property p_otp_write;
    st_q.otp_sel && (st_q.se_go || st_q.pp_go)
    |-> $past(st_q.pfield) == 3'b000 && !$past(st_q.lock);
  endproperty
  a_otp_write: assert property (p_otp_write) else $error("otp sector written"); // see RQ13

  property p_chip_prot;
    st_q.ce_go |-> $past(st_q.pfield) == 3'b000 && !st_q.otp_sel;
  endproperty
  a_chip_prot: assert property (p_chip_prot) else $error("chip erase protected"); // see RQ20

  property p_lockout;
    !st_q.pwr_done |-> !st_q.wel && st_q.pwr_cnt < LOCKOUT_CYCLES;
  endproperty
  a_lockout: assert property (p_lockout) else $error("write during lockout"); // see RQ18

  property p_lock_sticky;
    $past(st_q.lock) |-> st_q.lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared"); // see RQ21

endmodule : flash_id_otp_ctrl

//--- verilog/flash_otp_pkg.sv
package flash_otp_pkg;

  // instruction codes
  localparam logic [7:0] OP_READ_ID     = 8'h9f;
  localparam logic [7:0] OP_QUAD_ENABLE = 8'h38;
  localparam logic [7:0] OP_QUAD_RESET  = 8'hff;
  localparam logic [7:0] OP_OTP_ENTER   = 8'h3a;
  localparam logic [7:0] OP_WRITE_EN    = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
  localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE  = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;

  // identification bytes; the manufacturer value is arbitrary
  localparam logic [7:0] ID_MANUFACTURER = 8'h5a;
  localparam logic [7:0] ID_MEM_TYPE     = 8'h30;
  localparam logic [7:0] ID_CAPACITY     = 8'h13;

  // otp sector window while otp mode is active
  localparam logic [23:0] OTP_FIRST = 24'h07f000;
  localparam logic [23:0] OTP_LAST  = 24'h07f0ff;

  // reply lengths in bits, address length in bytes
  localparam logic [4:0] ID_BITS     = 5'h18;
  localparam logic [4:0] STATUS_BITS = 5'h08;
  localparam logic [1:0] ADDR_BYTES  = 2'h3;

  // status byte after reset
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // power-up write lockout
  localparam int unsigned CORE_CLK_KHZ   = 100000;
  localparam int unsigned LOCKOUT_MIN_MS = 1;
  localparam int unsigned LOCKOUT_MAX_MS = 10;
  localparam int unsigned LOCKOUT_CYC    = LOCKOUT_MIN_MS * CORE_CLK_KHZ;
  localparam int unsigned LOCKOUT_W      = 17;

  typedef enum logic [2:0] {
    S_CMD  = 3'b000,
    S_ADDR = 3'b001,
    S_DONE = 3'b011,
    S_WSR  = 3'b111,
    S_TX   = 3'b010,
    S_SKIP = 3'b110
  } ctrl_state_t;

endpackage : flash_otp_pkg

//--- verilog/serial_shifter.sv
`timescale 1ns/1ps
module serial_shifter (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_dq,
  output logic      [3:0] o_dq,
  output logic      [3:0] o_dq_oe_n,
  // controller side
  shift_if.phy            sif
);

  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [3:0]  dq_a;
    logic [3:0]  dq_b;
    logic        sck_p;
    logic        cs_p;
    logic [7:0]  sh;
    logic [2:0]  cnt;
    logic        rx_v;
    logic [7:0]  rx_b;
    logic        fs;
    logic        fe;
    logic [23:0] tx;
    logic [4:0]  txn;
    logic [3:0]  dout;
    logic [3:0]  oen;
  } phy_state_t;

  phy_state_t q, d;
  logic       rise;
  logic       fall;

  assign rise = q.sck_s[1] & ~q.sck_p;
  assign fall = ~q.sck_s[1] & q.sck_p;

  always_comb begin
    d       = q;
    d.rx_v  = 1'b0;
    d.fs    = 1'b0;
    d.fe    = 1'b0;
    d.sck_s = {q.sck_s[0], i_sck};
    d.cs_s  = {q.cs_s[0], i_cs_n};
    d.dq_a  = i_dq;
    d.dq_b  = q.dq_a;
    d.sck_p = q.sck_s[1];
    d.cs_p  = q.cs_s[1];
    if (q.cs_s[1]) begin
      // deselected: stop driving at once
      d.cnt = 3'h0;
      d.txn = 5'h00;
      d.oen = 4'hf;
      if (!q.cs_p) begin
        d.fe = 1'b1;
      end
    end else begin
      if (q.cs_p) begin
        d.fs = 1'b1;
      end
      if (rise) begin
        if (sif.quad) begin
          // four bits per edge in quad mode (see RQ7)
          d.sh  = {q.sh[3:0], q.dq_b};
          d.cnt = q.cnt + 3'h4;
          if (q.cnt == 3'h4) begin
            d.rx_v = 1'b1;
            d.rx_b = {q.sh[3:0], q.dq_b};
          end
        end else begin
          d.sh  = {q.sh[6:0], q.dq_b[0]};
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == 3'h7) begin
            d.rx_v = 1'b1;
            d.rx_b = {q.sh[6:0], q.dq_b[0]};
          end
        end
      end
      if (sif.tx_load) begin
        d.tx  = sif.tx_word;
        d.txn = sif.tx_bits;
      end else if (fall) begin
        // output changes on the falling edge only (see RQ3)
        if (q.txn == 5'h00) begin
          d.oen = 4'hf;
        end else if (sif.quad) begin
          d.dout = q.tx[23:20];
          d.oen  = 4'h0;
          d.tx   = {q.tx[19:0], 4'h0};
          d.txn  = q.txn - 5'h4;
        end else begin
          d.dout = {2'b00, q.tx[23], 1'b0};
          d.oen  = 4'hd;
          d.tx   = {q.tx[22:0], 1'b0};
          d.txn  = q.txn - 5'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q       <= '0;
      q.sck_s <= 2'b00;
      q.cs_s  <= 2'b11;
      q.cs_p  <= 1'b1;
      q.oen   <= 4'hf;
    end else begin
      q <= d;
    end
  end

  assign o_dq            = q.dout;
  assign o_dq_oe_n       = q.oen;
  assign sif.rx_valid    = q.rx_v;
  assign sif.rx_byte     = q.rx_b;
  assign sif.frame_start = q.fs;
  assign sif.frame_end   = q.fe;

endmodule : serial_shifter

//--- verilog/shift_if.sv
`timescale 1ns/1ps
interface shift_if;
  logic        quad;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        frame_start;
  logic        frame_end;
  logic        tx_load;
  logic [23:0] tx_word;
  logic [4:0]  tx_bits;

  modport phy (
    input  quad, tx_load, tx_word, tx_bits,
    output rx_valid, rx_byte, frame_start, frame_end
  );
  modport ctrl (
    output quad, tx_load, tx_word, tx_bits,
    input  rx_valid, rx_byte, frame_start, frame_end
  );
endinterface : shift_if
